// [cdw_wake.sv]
// Purpose: Charger-detect qualifier, wake sequencing, events and flags
// Assumes: Comparator outputs are asynchronous; host drives config bits
// Notes:   Functional notes below
//
// Functional notes
// R1: From shutdown, start up only after high input held 5 ms continuously.
// R2: External party holds charger-detect high at least 5 ms to wake.
// R3: From sleep/standby, return active after 2 ms high, if enabled.
// R4: Separate enables for standby/low-power return and sleep return.
// R5: Active-state flag set once startup or return to active completes.
// R6: Input above high threshold is a plug-in event.
// R7: Input below low threshold is a plug-out event.
// R8: Report combined, low-level and high-level detection flags.
// R9: Events reach GPIO interrupt only when routing is configured.
// R10: Hold 3-bit supply-compensation select, reset 000, 111 acts as 000.
// R11: Pulse-width count restarts whenever the input drops before done.
`timescale 1ns/1ps
`default_nettype none

module cdw_wake
   import cdw_pkg::*;
#(
   parameter int unsigned CNT_W = 12,
   parameter int unsigned TICK_DIV = SLOW_DIV
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_b_i,
   // Comparator outputs from the charger-detect pin
   input wire logic charger_high_cmp_i,
   input wire logic charger_low_cmp_i,
   // Host mode requests
   input wire logic enter_standby_i,
   input wire logic enter_sleep_i,
   input wire logic enter_shutdown_i,
   // Configuration
   input wire cdw_cfg_t cfg_i,
   input wire logic comp_wr_i,
   input wire logic [2:0] comp_wdata_i,
   // Status
   output logic active_state_flag_o,
   output cdw_det_t det_o,
   output logic [2:0] supply_comp_select_o,
   output logic [2:0] aux_regulator_code_o,
   output cdw_state_t state_o,
   // Interrupt to GPIO
   output logic plug_in_irq_o,
   output logic plug_out_irq_o
);

   // Counter must reach the wake count plus its spare tick; divider must fit 16 bits
   if (CNT_W < $clog2(WAKE_SHDN_TICKS + 2)) begin : g_cnt_w_chk
      $error("CNT_W too small for the wake count");
   end
   if (TICK_DIV < 2 || TICK_DIV > 65536) begin : g_div_chk
      $error("TICK_DIV outside the divider range");
   end

   // ----------------------------------------
   // Synchronisers and slow tick
   // ----------------------------------------
   logic [1:0] hi_sync_q, hi_sync_d, lo_sync_q, lo_sync_d;
   logic [15:0] div_q, div_d;
   logic tick_q, tick_d;

   always_comb begin
      hi_sync_d = {hi_sync_q[0], charger_high_cmp_i};
      lo_sync_d = {lo_sync_q[0], charger_low_cmp_i};
      tick_d = 1'b0;
      div_d = div_q + 16'h0001;
      if (div_q == 16'(TICK_DIV - 1)) begin
         div_d = 16'h0000;
         tick_d = 1'b1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         hi_sync_q <= 2'h0;
         // Low side resets to its idle level, so reset gives no false plug-out
         lo_sync_q <= 2'h3;
         div_q <= 16'h0000;
         tick_q <= 1'b0;
      end else begin
         hi_sync_q <= hi_sync_d;
         lo_sync_q <= lo_sync_d;
         div_q <= div_d;
         tick_q <= tick_d;
      end
   end

   wire logic high_s = hi_sync_q[1];
   // Low comparator is true when pin is below the plug-out threshold
   wire logic low_s = lo_sync_q[1];

   // ----------------------------------------
   // Pulse qualifier and state
   // ----------------------------------------
   logic [CNT_W-1:0] hcnt_q, hcnt_d;
   logic [CNT_W-1:0] scnt_q, scnt_d;
   cdw_state_t st_q, st_d;
   logic act_q, act_d;
   logic [CNT_W-1:0] need;

   always_comb begin
      // One spare tick covers the divider phase, so a wake never comes short of its least time
      need = (st_q == CDW_SHUTDOWN) ? CNT_W'(WAKE_SHDN_TICKS + 1) : CNT_W'(WAKE_LOW_TICKS + 1);
      hcnt_d = hcnt_q;
      if (!high_s) begin
         hcnt_d = '0; // R11
      end else if (tick_q && hcnt_q < need) begin
         hcnt_d = hcnt_q + CNT_W'(1);
      end
      st_d = st_q;
      scnt_d = scnt_q;
      act_d = act_q;
      case (st_q)
         CDW_SHUTDOWN: begin
            act_d = 1'b0;
            if (high_s && hcnt_q > CNT_W'(WAKE_SHDN_TICKS)) begin // R1 R2
               st_d = CDW_STARTUP;
               scnt_d = '0;
            end
         end
         CDW_STARTUP: begin
            if (tick_q) begin
               scnt_d = scnt_q + CNT_W'(1);
            end
            if (scnt_q == CNT_W'(STARTUP_TICKS)) begin
               st_d = CDW_ACTIVE;
               act_d = 1'b1; // R5
            end
         end
         CDW_ACTIVE: begin
            act_d = 1'b1;
            if (enter_shutdown_i) begin
               st_d = CDW_SHUTDOWN;
               act_d = 1'b0;
            end else if (enter_sleep_i) begin
               st_d = CDW_SLEEP;
               act_d = 1'b0;
            end else if (enter_standby_i) begin
               st_d = CDW_STANDBY;
               act_d = 1'b0;
            end
            hcnt_d = '0;
         end
         CDW_STANDBY, CDW_SLEEP: begin
            if (enter_shutdown_i) begin
               st_d = CDW_SHUTDOWN;
            end else if (high_s && hcnt_q > CNT_W'(WAKE_LOW_TICKS) &&
                         ((st_q == CDW_STANDBY && cfg_i.standby_wake_en) ||
                          (st_q == CDW_SLEEP && cfg_i.sleep_wake_en))) begin // R3 R4
               st_d = CDW_ACTIVE;
               act_d = 1'b1; // R5
            end
         end
         default: begin
            st_d = CDW_SHUTDOWN;
            act_d = 1'b0;
         end
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         hcnt_q <= '0;
         scnt_q <= '0;
         st_q <= CDW_SHUTDOWN;
         act_q <= 1'b0;
      end else begin
         hcnt_q <= hcnt_d;
         scnt_q <= scnt_d;
         st_q <= st_d;
         act_q <= act_d;
      end
   end

   // ----------------------------------------
   // Detection flags, events, compensation field
   // ----------------------------------------
   cdw_det_t det_q, det_d;
   logic hi_prev_q, lo_prev_q;
   logic pin_irq_q, pin_irq_d, pout_irq_q, pout_irq_d;
   logic [2:0] comp_q, comp_d;

   always_comb begin
      det_d.charger_high_flag = high_s; // R6 R8
      det_d.charger_low_flag = low_s; // R7 R8
      det_d.charger_detect_flag = high_s;
      // Events are one-cycle pulses; a level would hold the GPIO for the whole plug
      pin_irq_d = high_s && !hi_prev_q && cfg_i.plug_in_route_en; // R6 R9
      pout_irq_d = low_s && !lo_prev_q && cfg_i.plug_out_route_en; // R7 R9
      comp_d = comp_wr_i ? comp_wdata_i : comp_q; // R10
   end

   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         det_q <= '0;
         hi_prev_q <= 1'b0;
         lo_prev_q <= 1'b1;
         pin_irq_q <= 1'b0;
         pout_irq_q <= 1'b0;
         comp_q <= COMP_RST; // R10
         aux_regulator_code_o <= COMP_RST;
      end else begin
         det_q <= det_d;
         hi_prev_q <= high_s;
         lo_prev_q <= low_s;
         pin_irq_q <= pin_irq_d;
         pout_irq_q <= pout_irq_d;
         comp_q <= comp_d;
         // Code 111 drives the regulator exactly as 000
         aux_regulator_code_o <= (comp_d == COMP_ALIAS) ? COMP_RST : comp_d; // R10
      end
   end

   assign active_state_flag_o = act_q;
   assign det_o = det_q;
   assign supply_comp_select_o = comp_q;
   assign state_o = st_q;
   assign plug_in_irq_o = pin_irq_q;
   assign plug_out_irq_o = pout_irq_q;

endmodule : cdw_wake

`default_nettype wire

// [cdw_pkg.sv]
// Purpose: Shared constants and types for the charger-detect wake logic
// Assumes: 100 MHz system clock; slow tick derived by divider
// Notes:   Register positions kept as named constants for software reference
package cdw_pkg;

   // ----------------------------------------
   // Timing
   // ----------------------------------------
   localparam int unsigned CLK_HZ = 100_000_000;
   localparam int unsigned SLOW_HZ = 32_000;
   localparam int unsigned SLOW_DIV = CLK_HZ / SLOW_HZ;
   localparam int unsigned WAKE_SHDN_US = 5000;
   localparam int unsigned WAKE_LOW_US = 2000;
   // Least times round up to whole slow ticks
   localparam int unsigned WAKE_SHDN_TICKS = (WAKE_SHDN_US * (SLOW_HZ / 1000) + 999) / 1000;
   localparam int unsigned WAKE_LOW_TICKS = (WAKE_LOW_US * (SLOW_HZ / 1000) + 999) / 1000;
   localparam int unsigned STARTUP_TICKS = 4;

   // ----------------------------------------
   // Register positions
   // ----------------------------------------
   localparam logic [7:0] CFG_ADDR = 8'h01;
   localparam int unsigned CFG_STB_EN_BIT = 7;
   localparam int unsigned CFG_SLP_EN_BIT = 9;
   localparam logic [7:0] STATE_ADDR = 8'h1C;
   localparam int unsigned STATE_ACT_BIT = 0;
   localparam logic [7:0] DET_ADDR = 8'h27;
   localparam int unsigned DET_FLAG_BIT = 14;
   localparam int unsigned DET_LOW_BIT = 8;
   localparam int unsigned DET_HIGH_BIT = 9;
   localparam logic [7:0] COMP_ADDR = 8'h56;
   localparam int unsigned COMP_LSB = 1;
   localparam logic [2:0] COMP_RST = 3'h0;
   localparam logic [2:0] COMP_ALIAS = 3'h7;

   // ----------------------------------------
   // Types
   // ----------------------------------------
   typedef enum logic [2:0] {
      CDW_SHUTDOWN,
      CDW_STARTUP,
      CDW_ACTIVE,
      CDW_STANDBY,
      CDW_SLEEP
   } cdw_state_t;

   typedef struct packed {
      logic standby_wake_en;
      logic sleep_wake_en;
      logic plug_in_route_en;
      logic plug_out_route_en;
   } cdw_cfg_t;

   typedef struct packed {
      logic charger_detect_flag;
      logic charger_high_flag;
      logic charger_low_flag;
   } cdw_det_t;

endpackage : cdw_pkg

// [cdw_plug.sv]
// Purpose: Charger plug model feeding the detect comparators
// Assumes: Plug level set by the bench
// Notes: No middle band between the two thresholds
`timescale 1ns/1ps
`default_nettype none
module cdw_plug (
   // Plug state
   input wire logic plugged_i,
   // Comparators
   output logic high_o,
   output logic low_o
);
   assign high_o = plugged_i;
   assign low_o = !plugged_i;
endmodule : cdw_plug
`default_nettype wire

// [cdw_wake_chk.sv]
// Purpose: Port checks for the charger-detect wake logic
// Assumes: One clock, sync active-low reset
// Notes: Bound to cdw_wake
`timescale 1ns/1ps
`default_nettype none
module cdw_wake_chk
   import cdw_pkg::*;
#(
   parameter int unsigned DIV = SLOW_DIV
) (
   // Watched ports
   input wire logic clk_i,
   input wire logic rst_b_i,
   input wire logic charger_high_cmp_i,
   input wire cdw_cfg_t cfg_i,
   input wire logic comp_wr_i,
   input wire logic [2:0] comp_wdata_i,
   input wire logic active_state_flag_o,
   input wire cdw_det_t det_o,
   input wire logic [2:0] supply_comp_select_o,
   input wire logic [2:0] aux_regulator_code_o,
   input wire cdw_state_t state_o,
   input wire logic plug_in_irq_o,
   input wire logic plug_out_irq_o
);
   // Least raw high times at the wake edges, in clocks
   localparam int unsigned SHDN_MIN = WAKE_SHDN_TICKS * DIV;
   localparam int unsigned LOW_MIN = WAKE_LOW_TICKS * DIV;
   // Raw high time seen at the comparator port
   int hi_cnt;
   always_ff @(posedge clk_i) begin
      hi_cnt <= charger_high_cmp_i ? hi_cnt + 1 : 0;
   end
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_b_i);
   shdn_wake_a: assert property (state_o == CDW_SHUTDOWN ##1 state_o == CDW_STARTUP |-> hi_cnt >= SHDN_MIN)
      else $error("shutdown left early");
   low_wake_a: assert property ((state_o == CDW_STANDBY || state_o == CDW_SLEEP) ##1 state_o == CDW_ACTIVE
      |-> hi_cnt >= LOW_MIN) else $error("low power left early");
   sleep_en_a: assert property (state_o == CDW_SLEEP ##1 state_o == CDW_ACTIVE
      |-> $past(cfg_i.sleep_wake_en)) else $error("sleep wake disabled");
   stby_en_a: assert property (state_o == CDW_STANDBY ##1 state_o == CDW_ACTIVE
      |-> $past(cfg_i.standby_wake_en)) else $error("standby wake disabled");
   active_flag_a: assert property (active_state_flag_o == (state_o == CDW_ACTIVE))
      else $error("active flag wrong");
   in_pulse_a: assert property (plug_in_irq_o |-> $past(cfg_i.plug_in_route_en) ##1 !plug_in_irq_o)
      else $error("plug-in irq wrong");
   out_route_a: assert property (plug_out_irq_o |-> $past(cfg_i.plug_out_route_en))
      else $error("plug-out irq unrouted");
   det_comb_a: assert property (det_o.charger_detect_flag == det_o.charger_high_flag)
      else $error("combined flag wrong");
   comp_store_a: assert property (comp_wr_i |=> supply_comp_select_o == $past(comp_wdata_i))
      else $error("select not stored");
   comp_alias_a: assert property (aux_regulator_code_o == (supply_comp_select_o == 3'h7 ? 3'h0
      : supply_comp_select_o)) else $error("code alias wrong");
   cover property (state_o == CDW_STARTUP);
   cover property (plug_out_irq_o);
   cover property (state_o == CDW_SLEEP ##1 state_o == CDW_ACTIVE);
endmodule : cdw_wake_chk
bind cdw_wake cdw_wake_chk #(.DIV(TICK_DIV)) u_chk (.clk_i, .rst_b_i, .charger_high_cmp_i, .cfg_i, .comp_wr_i,
   .comp_wdata_i,
   .active_state_flag_o, .det_o, .supply_comp_select_o, .aux_regulator_code_o, .state_o, .plug_in_irq_o,
   .plug_out_irq_o);
`default_nettype wire

// [cdw_wake_tb_top.sv]
// Purpose: Self-checking bench for the charger-detect wake logic
// Assumes: Package timing constants, 100 MHz clock
// Notes: Slow tick divider shortened so the wake spans stay brief
`timescale 1ns/1ps
`default_nettype none
module cdw_wake_tb_top;
   import cdw_pkg::*;
   // Short slow tick; all wake spans scale with it
   localparam int unsigned DIV = 8;
   logic clk_i = 1'b0;
   logic rst_b_i = 1'b0;
   logic plugged = 1'b0;
   logic stby_r = 1'b0;
   logic slp_r = 1'b0;
   logic comp_wr = 1'b0;
   logic [2:0] comp_wd = 3'h0;
   cdw_cfg_t cfg = 4'h2;
   logic hi_c, lo_c, act, irq_in, irq_out;
   logic [2:0] sel, aux;
   cdw_det_t det;
   cdw_state_t st;
   int bad_count = 0, check_count = 0, in_cnt = 0, out_cnt = 0;
   always #5 clk_i = ~clk_i;
   always @(posedge clk_i) begin
      if (irq_in === 1'b1) in_cnt <= in_cnt + 1;
      if (irq_out === 1'b1) out_cnt <= out_cnt + 1;
   end
   cdw_plug u_plug (.plugged_i(plugged), .high_o(hi_c), .low_o(lo_c));
   cdw_wake #(.TICK_DIV(DIV)) dut (.clk_i, .rst_b_i, .charger_high_cmp_i(hi_c), .charger_low_cmp_i(lo_c),
      .enter_standby_i(stby_r), .enter_sleep_i(slp_r), .enter_shutdown_i(1'b0), .cfg_i(cfg),
      .comp_wr_i(comp_wr), .comp_wdata_i(comp_wd), .active_state_flag_o(act), .det_o(det),
      .supply_comp_select_o(sel), .aux_regulator_code_o(aux), .state_o(st),
      .plug_in_irq_o(irq_in), .plug_out_irq_o(irq_out));
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      check_count++;
      if (seen !== exp) begin
         bad_count++;
         $display("MISMATCH %0t: saw %h want %h", $time, seen, exp);
      end
   endtask : check
   task automatic hold(input logic lvl, input int n);
      @(posedge clk_i);
      plugged <= lvl;
      repeat (n) @(posedge clk_i);
      #1;
   endtask : hold
   task automatic t_comp();
      check(8'(sel), 8'h00);
      for (int i = 0; i < 8; i++) begin
         @(posedge clk_i);
         comp_wr <= 1'b1;
         comp_wd <= 3'(i);
         @(posedge clk_i);
         comp_wr <= 1'b0;
         @(posedge clk_i);
         #1 check(8'(sel), 8'(i));
         check(8'(aux), i == 7 ? 8'h00 : 8'(i));
      end
   endtask : t_comp
   task automatic t_shdn();
      hold(1'b1, WAKE_SHDN_TICKS * DIV * 3 / 4);
      check(8'(det), 8'h06);
      hold(1'b0, 10);
      check(8'(det), 8'h01);
      check(8'(out_cnt), 8'h00);
      hold(1'b1, WAKE_SHDN_TICKS * DIV * 3 / 4);
      check(8'(st), 8'(CDW_SHUTDOWN));
      hold(1'b1, WAKE_SHDN_TICKS * DIV / 2);
      check(8'(st), 8'(CDW_ACTIVE));
      check(8'(act), 8'h01);
      check(8'(in_cnt), 8'h02);
   endtask : t_shdn
   task automatic t_wake(input logic slp, input logic en, input cdw_state_t want);
      hold(1'b0, 10);
      @(posedge clk_i);
      stby_r <= !slp;
      slp_r <= slp;
      cfg.standby_wake_en <= en & !slp;
      cfg.sleep_wake_en <= en & slp;
      @(posedge clk_i);
      stby_r <= 1'b0;
      slp_r <= 1'b0;
      hold(1'b1, WAKE_LOW_TICKS * DIV * 3 / 2);
      check(8'(st), 8'(want));
      check(8'(act), 8'(want == CDW_ACTIVE));
   endtask : t_wake
   task automatic stop_test();
      if (bad_count == 0 && check_count > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : stop_test
   initial begin
      repeat (4) @(posedge clk_i);
      rst_b_i <= 1'b1;
      t_comp();
      t_shdn();
      @(posedge clk_i);
      cfg.plug_out_route_en <= 1'b1;
      t_wake(1'b0, 1'b0, CDW_STANDBY);
      t_wake(1'b0, 1'b1, CDW_ACTIVE);
      t_wake(1'b1, 1'b1, CDW_ACTIVE);
      check(8'(in_cnt), 8'h05);
      check(8'(out_cnt), 8'h03);
      stop_test();
   end
   initial begin
      repeat (20000) @(posedge clk_i);
      bad_count++;
      stop_test();
   end
endmodule : cdw_wake_tb_top
`default_nettype wire
